// ---- verilog/charge_port_mode_control.sv ----
`timescale 1ns/1ps
`include "charge_port_defines.svh"

module charge_port_mode_control #(
    parameter int unsigned LONG_CYCLES = `LONG_DISCHARGE_CYCLES,
    parameter int unsigned SHORT_CYCLES = `SHORT_DISCHARGE_CYCLES,
    parameter int unsigned DWELL_CYCLES = `AUTO_DWELL_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic mode_select_bit_a,
    input wire logic mode_select_bit_b,
    input wire logic mode_select_bit_c,
    input wire logic current_threshold_select,
    input wire logic enable,
    input wire logic current_limiting,
    input wire logic load_present,
    output logic data_switch_en,
    output logic power_switch_en,
    output logic discharge_en,
    output logic high_current_limit,
    output charge_port_pkg::mode_t active_mode,
    output charge_port_pkg::scheme_t dcp_scheme
);
    import charge_port_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        pins_t sync1;              // first synchroniser stage
        pins_t sync2;              // second synchroniser stage
        logic pins_valid;          // set one cycle after reset; sync2 holds a real sample one cycle later
        mode_t mode;               // registered mode
        logic [31:0] dis_count;    // remaining discharge cycles
        switch_ctl_t ctl;          // registered switch enables
        logic ilim_high;           // registered current range
    } ctl_state_t;

    ctl_state_t state;
    ctl_state_t next_state;
    mode_t decoded;
    scheme_t auto_scheme;
    logic needs_cycle;
    logic [31:0] dis_len;

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    function automatic mode_t decode(input logic [2:0] sel, input logic ilim);
        mode_t m;
        m = mode_discharge;
        // mode comes from the three pins, plus the range pin for 111
        case (sel)
            3'h0: m = mode_discharge;
            3'h1: m = mode_dcp_auto;
            3'h2: m = mode_sdp1;
            3'h3: m = mode_dcp_auto;
            3'h4: m = mode_dcp_shorted;
            3'h5: m = mode_dcp_ratio;
            3'h6: m = mode_sdp1;
            3'h7: m = ilim ? mode_cdp : mode_sdp2;
            default: m = mode_discharge;
        endcase
        return m;
    endfunction

    function automatic logic is_data(input mode_t m);
        return (m == mode_sdp1) || (m == mode_sdp2) || (m == mode_cdp);
    endfunction

    function automatic logic is_dcp(input mode_t m);
        return (m == mode_dcp_auto) || (m == mode_dcp_shorted) || (m == mode_dcp_ratio);
    endfunction

    // ----------------------------------------
    // transition analysis
    // ----------------------------------------
    always_comb begin
        decoded = decode(state.sync2.mode_select, state.sync2.current_threshold_select);
        // change out of SDP1/CDP, or from DCP into CDP/SDP, cycles the power path
        needs_cycle = (decoded != state.mode) &&
                      (is_data(decoded) || is_data(state.mode));
        // no discharge between CDP and SDP2
        if ((state.mode == mode_cdp && decoded == mode_sdp2) ||
            (state.mode == mode_sdp2 && decoded == mode_cdp)) begin
            needs_cycle = 1'b0;
        end
        // leaving SDP1/CDP takes the long time, DCP the short one
        if (state.mode == mode_sdp1 || state.mode == mode_cdp) begin
            dis_len = LONG_CYCLES;
        end else if (is_dcp(state.mode)) begin
            dis_len = SHORT_CYCLES;
        end else begin
            dis_len = 32'h0;
        end
        if (dis_len == 32'h0) begin
            needs_cycle = 1'b0;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_state.sync1 = '{enable: enable,
                             current_threshold_select: current_threshold_select,
                             mode_select: {mode_select_bit_a, mode_select_bit_b,
                                           mode_select_bit_c}};
        next_state.sync2 = state.sync1;
        next_state.pins_valid = 1'b1;
        if (state.pins_valid) begin
            next_state.mode = decoded;
        end
        // discharge timer
        if (state.pins_valid && needs_cycle) begin
            next_state.dis_count = dis_len;
        end else if (state.dis_count != 32'h0) begin
            next_state.dis_count = state.dis_count - 32'h1;
        end
        // data switches follow only mode, enable and pins_valid
        next_state.ctl.data_switch_en = state.sync2.enable && is_data(decoded) &&
                                        state.pins_valid;
        // 000 with enable forces power off with discharge
        if (!state.pins_valid || !state.sync2.enable) begin
            next_state.ctl.power_switch_en = 1'b0;
            next_state.ctl.discharge_en = 1'b0;
        end else if (decoded == mode_discharge) begin
            next_state.ctl.power_switch_en = 1'b0;
            next_state.ctl.discharge_en = 1'b1;
        end else if (needs_cycle || next_state.dis_count != 32'h0) begin
            // power off while discharging, back on when done
            next_state.ctl.power_switch_en = 1'b0;
            next_state.ctl.discharge_en = 1'b1;
        end else begin
            next_state.ctl.power_switch_en = 1'b1;
            next_state.ctl.discharge_en = 1'b0;
        end
        // detection machine runs only in auto DCP
        next_state.ctl.auto_detect_en = state.pins_valid && state.sync2.enable &&
                                        decoded == mode_dcp_auto;
        // auto DCP and CDP modes use the high range, other modes follow the range pin
        next_state.ilim_high = state.sync2.current_threshold_select ||
                               decoded == mode_dcp_auto;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // all switches off in reset
            state <= '{sync1: '0, sync2: '0, pins_valid: 1'b0, mode: mode_discharge,
                       dis_count: 32'h0, ctl: '0, ilim_high: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // auto-detect machine
    // ----------------------------------------
    dcp_auto_detect #(
        .DWELL_CYCLES(DWELL_CYCLES)
    ) u_detect (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(state.ctl.auto_detect_en),
        .load_present(load_present),
        .scheme(auto_scheme)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        // forced DCP shows one fixed scheme while the power switch is on, none otherwise
        case (state.mode)
            mode_dcp_shorted: dcp_scheme = state.ctl.power_switch_en ? scheme_shorted : scheme_none;
            mode_dcp_ratio: dcp_scheme = state.ctl.power_switch_en ? scheme_ratio_one : scheme_none;
            mode_dcp_auto: dcp_scheme = auto_scheme;
            default: dcp_scheme = scheme_none;
        endcase
    end

    assign data_switch_en = state.ctl.data_switch_en;
    assign power_switch_en = state.ctl.power_switch_en;
    assign discharge_en = state.ctl.discharge_en;
    assign high_current_limit = state.ilim_high;
    assign active_mode = state.mode;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    data_needs_enable_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        data_switch_en |-> $past(state.sync2.enable))
        else $error("data switch closed while disabled");
    data_off_dcp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_dcp(active_mode) |-> !data_switch_en)
        else $error("data switch closed in DCP mode");
    cdp_data_on_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (active_mode == mode_cdp && $past(state.sync2.enable) && $past(state.pins_valid))
        |-> data_switch_en)
        else $error("data switch open in CDP");
    limit_no_effect_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(current_limiting) && $stable(state.sync2) && data_switch_en
        |=> data_switch_en)
        else $error("current limit opened data switch");
    zero_mode_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        active_mode == mode_discharge && $past(state.sync2.enable) && $past(state.pins_valid)
        |-> !power_switch_en && discharge_en && !data_switch_en)
        else $error("000 mode outputs wrong");
    forced_scheme_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        active_mode == mode_dcp_ratio |-> dcp_scheme != scheme_shorted)
        else $error("forced ratio mode shows shorted scheme");
    auto_run_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        state.ctl.auto_detect_en |-> active_mode == mode_dcp_auto)
        else $error("auto detect runs outside auto mode");
    cycle_power_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        state.pins_valid && needs_cycle && state.sync2.enable
        |=> !power_switch_en && discharge_en)
        else $error("mode change without power cycle");
    // a powered port stays powered across a CDP/SDP2 swap, seen on the outputs
    no_cdp_sdp2_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        ((active_mode == mode_sdp2 && $past(active_mode) == mode_cdp) ||
         (active_mode == mode_cdp && $past(active_mode) == mode_sdp2)) &&
        $past(power_switch_en) && $past(state.sync2.enable)
        |-> power_switch_en && !discharge_en)
        else $error("discharge between CDP and SDP2");
    reset_off_a: assert property (@(posedge core_clk)
        !arst_n |-> !data_switch_en && !power_switch_en)
        else $error("switch on during reset");

    cov_cdp_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        active_mode == mode_cdp && data_switch_en);
    cov_discharge_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        $rose(discharge_en));
    cov_auto_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        dcp_scheme == scheme_ratio_two);
    cov_repower_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        $fell(discharge_en) && power_switch_en);
endmodule

// ---- include/charge_port_defines.svh ----
`ifndef CHARGE_PORT_DEFINES_SVH
`define CHARGE_PORT_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define LONG_DISCHARGE_MS 2000
`define SHORT_DISCHARGE_MS 250
`define LONG_DISCHARGE_CYCLES ((`LONG_DISCHARGE_MS * 1000000) / `CLK_PERIOD_NS)
`define SHORT_DISCHARGE_CYCLES ((`SHORT_DISCHARGE_MS * 1000000) / `CLK_PERIOD_NS)
// dwell in one auto-detect scheme before trying the next
`define AUTO_DWELL_CYCLES 1000000

// ----------------------------------------
// field positions of mode select
// ----------------------------------------
`define SEL_BIT_A 2
`define SEL_BIT_B 1
`define SEL_BIT_C 0

`endif

// ---- include/charge_port_pkg.sv ----
package charge_port_pkg;

    // charging mode after decode
    typedef enum logic [2:0] {
        mode_discharge,
        mode_dcp_auto,
        mode_sdp1,
        mode_sdp2,
        mode_cdp,
        mode_dcp_shorted,
        mode_dcp_ratio
    } mode_t;

    // data-line scheme presented on the port
    typedef enum logic [2:0] {
        scheme_none,
        scheme_shorted,
        scheme_ratio_one,
        scheme_ratio_two,
        scheme_one_v_two
    } scheme_t;

    // switch enables driven by the block
    typedef struct packed {
        logic data_switch_en;
        logic power_switch_en;
        logic discharge_en;
        logic auto_detect_en;
    } switch_ctl_t;

    // synchronised control pins
    typedef struct packed {
        logic enable;
        logic current_threshold_select;
        logic [2:0] mode_select;
    } pins_t;

endpackage

// ---- verilog/dcp_auto_detect.sv ----
`timescale 1ns/1ps
`include "charge_port_defines.svh"

// steps through all four DCP schemes while enabled; a scheme is held
// while the attached device loads the port, otherwise the next one is tried
module dcp_auto_detect #(
    parameter int unsigned DWELL_CYCLES = `AUTO_DWELL_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic load_present,
    output charge_port_pkg::scheme_t scheme
);
    import charge_port_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        scheme_t scheme;
        logic [31:0] dwell;
    } det_state_t;

    det_state_t state;
    det_state_t next_state;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        if (!run) begin
            // idle: no scheme presented
            next_state.scheme = scheme_none;
            next_state.dwell = 32'h0;
        end else if (state.scheme == scheme_none) begin
            // start with the shorted scheme
            next_state.scheme = scheme_shorted;
            next_state.dwell = 32'h0;
        end else if (load_present) begin
            // device accepted this scheme: hold it
            next_state.dwell = 32'h0;
        end else if (state.dwell >= DWELL_CYCLES - 1) begin
            next_state.dwell = 32'h0;
            // rotate among the four schemes
            case (state.scheme)
                scheme_shorted: next_state.scheme = scheme_ratio_one;
                scheme_ratio_one: next_state.scheme = scheme_ratio_two;
                scheme_ratio_two: next_state.scheme = scheme_one_v_two;
                default: next_state.scheme = scheme_shorted;
            endcase
        end else begin
            next_state.dwell = state.dwell + 32'h1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '{scheme: scheme_none, dwell: 32'h0};
        end else begin
            state <= next_state;
        end
    end

    assign scheme = state.scheme;

    scheme_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !run |=> scheme == scheme_none)
        else $error("auto detect scheme active while not running");
endmodule

// ---- sim/host_pin_driver.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// host controller model
// ----------------------------------------
// stands in for the system logic that drives the mode pins; pins move
// only after a falling edge so they never race the sampling edge
module host_pin_driver (
    input wire logic core_clk,
    input wire logic [3:0] req_code,
    input wire logic req_enable,
    input wire logic req_load,
    output logic mode_select_bit_a,
    output logic mode_select_bit_b,
    output logic mode_select_bit_c,
    output logic current_threshold_select,
    output logic enable,
    output logic load_present
);
    // pins start low so the design sees known levels at time zero
    initial begin
        mode_select_bit_a = 1'b0;
        mode_select_bit_b = 1'b0;
        mode_select_bit_c = 1'b0;
        current_threshold_select = 1'b0;
        enable = 1'b0;
        load_present = 1'b0;
    end

    // mode is set only by the three select pins plus the range pin
    always @(negedge core_clk) begin
        mode_select_bit_a <= req_code[3];
        mode_select_bit_b <= req_code[2];
        mode_select_bit_c <= req_code[1];
        current_threshold_select <= req_code[0];
        enable <= req_enable;
        load_present <= req_load;
    end
endmodule

// ---- sim/charge_port_mode_control_tb_top.sv ----
`timescale 1ns/1ps

module charge_port_mode_control_tb_top;
    import charge_port_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int unsigned LONG = 20; // shortened long discharge
    localparam int unsigned SHORT = 5; // shortened short discharge
    logic core_clk = 1'b0;
    logic arst_n = 1'b1; // pulled low just after time zero so the reset edge is seen
    logic current_limiting = 1'b0; // driven at random, must not matter
    logic [3:0] req_code = 4'h0; // {a, b, c, range select}
    logic req_enable = 1'b0;
    logic req_load = 1'b0;
    logic sel_a, sel_b, sel_c, ilim, en_pin, load;
    logic data_switch_en, power_switch_en, discharge_en, high_current_limit;
    mode_t active_mode;
    scheme_t dcp_scheme;
    int mismatches = 0;
    int checks_done = 0;

    always #5 core_clk = ~core_clk;

    host_pin_driver host_pin_driver_inst (.core_clk(core_clk), .req_code(req_code),
        .req_enable(req_enable), .req_load(req_load), .mode_select_bit_a(sel_a),
        .mode_select_bit_b(sel_b), .mode_select_bit_c(sel_c),
        .current_threshold_select(ilim), .enable(en_pin), .load_present(load));

    charge_port_mode_control #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT), .DWELL_CYCLES(8))
    charge_port_mode_control_inst (.core_clk(core_clk), .arst_n(arst_n),
        .mode_select_bit_a(sel_a), .mode_select_bit_b(sel_b), .mode_select_bit_c(sel_c),
        .current_threshold_select(ilim), .enable(en_pin),
        .current_limiting(current_limiting), .load_present(load),
        .data_switch_en(data_switch_en), .power_switch_en(power_switch_en),
        .discharge_en(discharge_en), .high_current_limit(high_current_limit),
        .active_mode(active_mode), .dcp_scheme(dcp_scheme));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // expected decoded mode of a pin setting
    function automatic mode_t exp_mode(input logic [3:0] c);
        case (c[3:1])
            3'h0: return mode_discharge;
            3'h1, 3'h3: return mode_dcp_auto;
            3'h2, 3'h6: return mode_sdp1;
            3'h4: return mode_dcp_shorted;
            3'h5: return mode_dcp_ratio;
            default: return c[0] ? mode_cdp : mode_sdp2;
        endcase
    endfunction

    // one comparison, reported at once on a mismatch
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // new request after a falling edge, current limiting toggled at random
    task automatic apply(input logic [3:0] code, input logic en);
        @(negedge core_clk);
        // non-blocking so the pin model takes the request one edge later, with no race
        req_code <= code;
        req_enable <= en;
        current_limiting <= 1'($urandom);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // outputs once every discharge interval has run out
    task automatic check_steady(input logic [3:0] code, input logic en);
        mode_t m;
        logic dm;
        m = exp_mode(code);
        dm = (m == mode_sdp1) || (m == mode_sdp2) || (m == mode_cdp);
        check("mode", active_mode, m);
        check("data switch", data_switch_en, en & dm);
        check("power", power_switch_en, en & (m != mode_discharge));
        check("discharge", discharge_en, en & (m == mode_discharge));
        if (en) begin
            check("range", high_current_limit, code[0] | (m == mode_dcp_auto));
        end
        if (en && m == mode_dcp_shorted) begin
            check("scheme", dcp_scheme, scheme_shorted);
        end
        if (en && m == mode_dcp_ratio) begin
            check("scheme", dcp_scheme, scheme_ratio_one);
        end
    endtask

    // ----------------------------------------
    // closing
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        stop_test;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    logic [3:0] from_c [5] = '{4'h4, 4'hF, 4'hE, 4'h8, 4'hF};
    logic [3:0] to_c [5] = '{4'hF, 4'hE, 4'hF, 4'h4, 4'h2};
    int exp_len [5] = '{LONG, 0, 0, SHORT, LONG};

    initial begin
        int cnt;
        int drop;
        int overlap;
        logic [4:0] seen;
        scheme_t held;
        void'($urandom(32'hAFBA2BC7));
        #1;
        arst_n = 1'b0;
        // switches stay off while reset is held
        settle(3);
        check("reset data", data_switch_en, 1'b0);
        check("reset power", power_switch_en, 1'b0);
        settle(3);
        arst_n = 1'b1;
        // full decode table, with and without enable
        for (int i = 0; i < 32; i++) begin
            apply(i[3:0], i[4]);
            settle(40);
            check_steady(i[3:0], i[4]);
        end
        $display("test decode done");
        // discharge lengths per transition, data held during discharge
        for (int t = 0; t < 5; t++) begin
            apply(from_c[t], 1'b1);
            settle(40);
            apply(to_c[t], 1'b1);
            cnt = 0;
            drop = 0;
            overlap = 0;
            for (int i = 0; i < 60; i++) begin
                @(negedge core_clk);
                cnt += int'(discharge_en);
                if (i >= 4 && to_c[t][2] && data_switch_en !== 1'b1) drop++;
                // power path must be off exactly while the output discharges
                if (discharge_en === power_switch_en) overlap++;
            end
            check("discharge len", 8'(cnt), 8'(exp_len[t]));
            check("data dropped", 8'(drop), 0);
            check("power vs discharge", 8'(overlap), 0);
            check("repower", power_switch_en, 1'b1);
        end
        $display("test discharge done");
        // auto detect walks all four schemes, then holds under load
        apply(4'h2, 1'b1);
        settle(40);
        seen = '0;
        for (int i = 0; i < 80; i++) begin
            @(negedge core_clk);
            seen[dcp_scheme] = 1'b1;
        end
        check("auto schemes", {3'h0, seen}, 8'h1E);
        req_load <= 1'b1;
        settle(4);
        held = dcp_scheme;
        cnt = 0;
        for (int i = 0; i < 30; i++) begin
            @(negedge core_clk);
            if (dcp_scheme !== held) cnt++;
        end
        check("auto hold", 8'(cnt), 0);
        req_load <= 1'b0;
        $display("test auto done");
        // random settings
        repeat (24) begin
            cnt = int'($urandom);
            apply(cnt[3:0], cnt[4] | cnt[5]);
            settle(40);
            check_steady(cnt[3:0], cnt[4] | cnt[5]);
        end
        $display("test random done");
        // second reset in mid-run drops every switch at once
        apply(4'hF, 1'b1);
        settle(40);
        arst_n = 1'b0;
        #1;
        check("mid reset data", data_switch_en, 1'b0);
        check("mid reset power", power_switch_en, 1'b0);
        settle(2);
        arst_n = 1'b1;
        settle(40);
        check_steady(4'hF, 1'b1);
        $display("test reset done");
        stop_test;
    end
endmodule
